// *** bench/acs_adc_model.sv ***
// acs_adc_model.sv: analog core stand-in giving a fixed sample
// assumes: sampled by the sequencer on pclk at conversion end
`timescale 1ns/10ps
module acs_adc_model
#(
	parameter [11:0] SAMPLE = 12'habc
)
(
	// clock
	input wire pclk,
	// converter
	input wire conv_sample_reg,
	output reg [11:0] conv_sample
);
	// ****
	// sample drive
	// ****
	initial conv_sample = 12'h000;
	// churns outside a conversion so a stale capture shows
	always @(posedge pclk)
		conv_sample <= conv_sample_reg ? SAMPLE : ~conv_sample;
endmodule // acs_adc_model

// *** bench/acs_seq_monitor.sv ***
// acs_seq_monitor.sv: port assertions for the a/d sequencer
// assumes: bound into acs_seq, single pclk domain
`timescale 1ns/10ps
module acs_seq_monitor
#(
	parameter CONV_CLKS = 16
)
(
	// apb
	input wire pclk,
	input wire presetn,
	input wire pready,
	input wire [31:0] prdata,
	// converter
	input wire conv_reset_reg,
	input wire conv_sample_reg,
	input wire conv_power_off,
	input wire internal_source_sel,
	input wire [3:0] analog_mux_sel,
	// pins
	input wire [3:0] pin_analog_en,
	input wire [3:0] pin_pullup_dis,
	input wire [3:0] pin_dir_override
);
	// ****
	// checks
	// ****
	reg [10:0] run_reg;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// run length of one conversion, slowest code is /64
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_reg <= 11'h000;
		else
			run_reg <= conv_sample_reg ? run_reg + 11'h001 : 11'h000;
	end
	AST_CONV_LEN: assert property ($fell(conv_sample_reg) && !conv_reset_reg |->
		run_reg >= CONV_CLKS - 1 && run_reg <= 64 * CONV_CLKS + 2) else $error("bad length");
	AST_PULLUP: assert property (pin_pullup_dis == pin_analog_en)
		else $error("pull-high kept");
	AST_DIR: assert property (pin_dir_override == pin_analog_en)
		else $error("direction kept");
	AST_MUX_HOT: assert property ($onehot0(analog_mux_sel))
		else $error("mux not one-hot");
	AST_MUX_INT: assert property (internal_source_sel [*2] |-> analog_mux_sel == 4'h0)
		else $error("channel left on");
	AST_POFF: assert property (conv_power_off [*2] |-> conv_reset_reg)
		else $error("not held off");
	AST_RST_IDLE: assert property (conv_reset_reg |-> !conv_sample_reg)
		else $error("converting in reset");
	AST_RD_UPPER: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper bits set");
endmodule // acs_seq_monitor
bind acs_seq acs_seq_monitor #(.CONV_CLKS(CONV_CLKS)) u_acs_seq_monitor (.pclk(pclk),
	.presetn(presetn), .pready(pready), .prdata(prdata), .conv_reset_reg(conv_reset_reg),
	.conv_sample_reg(conv_sample_reg), .conv_power_off(conv_power_off),
	.internal_source_sel(internal_source_sel), .analog_mux_sel(analog_mux_sel),
	.pin_analog_en(pin_analog_en), .pin_pullup_dis(pin_pullup_dis),
	.pin_dir_override(pin_dir_override));

// *** bench/tb_top.sv ***
// tb_top.sv: self-checking bench for the a/d sequencer
// assumes: apb master here, analog core from acs_adc_model
`timescale 1ns/10ps
module tb_top;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r;} acs_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_irq, se;
	logic conv_reset_reg, conv_sample_reg, conv_power_off, internal_source_sel;
	logic bandgap_en, ref_source_sel;
	logic [11:0] paddr, conv_sample;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] analog_mux_sel, pin_analog_en, pin_pullup_dis, pin_dir_override;
	int errors = 0;
	int n_checks = 0;
	int n;
	int cyc = 0;
	acs_row_t rows[7] = '{'{12'h008, 32'hff, 32'h0f}, '{12'h008, 32'h05, 32'h05},
		'{12'h004, 32'hfe, 32'h76}, '{12'h004, 32'h00, 32'h00}, '{12'h000, 32'h13, 32'h53},
		'{12'h014, 32'h09, 32'h09}, '{12'h018, 32'h5a, 32'h00}};
	acs_seq u_acs_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .conv_sample, .conv_reset_reg, .conv_sample_reg, .conv_power_off,
		.analog_mux_sel, .internal_source_sel, .bandgap_en, .ref_source_sel, .pin_analog_en,
		.pin_pullup_dis, .pin_dir_override, .conv_irq);
	acs_adc_model u_acs_adc_model (.pclk, .conv_sample_reg, .conv_sample);
	// ****
	// tasks
	// ****
	task conclude;
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'h1 && k < 9);
		if (pready !== 1'h1)
		begin
			errors++;
			conclude;
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// one conversion; q enables the interrupt
	task conv(input [7:0] c1, input [31:0] hi, input [31:0] lo, input q);
		apb(1'h1, 12'h004, {24'h0, c1});
		apb(1'h1, 12'h000, 32'h01);
		apb(1'h1, 12'h014, q ? 32'h09 : 32'h00);
		apb(1'h1, 12'h000, 32'h81);
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'hc1);
		chk(conv_reset_reg, 1);
		apb(1'h1, 12'h000, 32'h01);
		chk(analog_mux_sel, 4'h2);
		n = cyc;
		do
			apb(1'h0, 12'h000, 32'h0);
		while (rd[6] !== 1'h0 && cyc - n < 1200);
		if (rd[6] !== 1'h0)
		begin
			errors++;
			conclude;
		end
		chk(cyc - n >= (16 << c1[2:0]) && cyc - n <= (16 << c1[2:0]) + 12, 1);
		apb(1'h0, 12'h014, 32'h0);
		chk(rd, q ? 32'h49 : 32'h40);
		chk(conv_irq, q);
		apb(1'h0, 12'h00c, 32'h0);
		chk(rd, hi);
		apb(1'h0, 12'h010, 32'h0);
		chk(rd, lo);
		chk({bandgap_en, ref_source_sel}, {c1[6], c1[4]});
		apb(1'h1, 12'h014, q ? 32'h09 : 32'h00);
		apb(1'h0, 12'h014, 32'h0);
		chk(rd, q ? 32'h09 : 32'h00);
		chk(conv_irq, 0);
	endtask
	// ****
	// stimulus
	// ****
	always @(posedge pclk)
		cyc <= cyc + 1;
	initial
	begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		chk(conv_power_off, 1);
		chk(conv_reset_reg, 1);
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h60);
		foreach (rows[i])
		begin
			apb(1'h1, rows[i].a, rows[i].w);
			apb(1'h0, rows[i].a, 32'h0);
			chk(rd, rows[i].r);
		end
		chk(se, 1);
		chk(pin_analog_en, 4'h5);
		chk(pin_pullup_dis, 4'h5);
		chk(pin_dir_override, 4'h5);
		chk(analog_mux_sel, 4'h0);
		chk(internal_source_sel, 1);
		conv(8'h56, 32'hab, 32'hc0, 1'h1);
		conv(8'h26, 32'h0a, 32'hbc, 1'h0);
		// abort: a fresh start mid-conversion resets the converter
		apb(1'h1, 12'h000, 32'h81);
		apb(1'h1, 12'h000, 32'h01);
		repeat (200) @(posedge pclk);
		chk(conv_sample_reg, 1);
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h41);
		apb(1'h1, 12'h000, 32'h81);
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'hc1);
		chk(conv_sample_reg, 0);
		chk(conv_reset_reg, 1);
		// reset in mid-run, start still held high
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk(pin_analog_en, 4'h0);
		chk(conv_irq, 0);
		presetn <= 1'h1;
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h60);
		apb(1'h0, 12'h008, 32'h0);
		chk(rd, 32'h00);
		conclude;
	end
endmodule // tb_top

// *** hdl/acs_clk_div.v ***
// acs_clk_div.v: converter clock tick generator, pclk divided by 1..64
// assumes: same clock domain as the sequencer, code 111 never selected
`timescale 1ns/10ps
`include "acs_map.vh"
module acs_clk_div
(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// control
	input wire clr,
	input wire [2:0] div_sel,
	// tick
	output reg tick_reg
);

reg [5:0] cnt_reg;
wire [5:0] limit;

// ****************************************
// divider
// ****************************************
// divide by 2**code; undefined code falls back to the slowest ratio
assign limit = (div_sel == `ACS_DIV_UNDEF) ? 6'h3f : ((6'h01 << div_sel) - 6'h01);

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		cnt_reg <= 6'h00;
		tick_reg <= 1'b0;
	end
	else if (clr)
	begin
		cnt_reg <= 6'h00;
		tick_reg <= 1'b0;
	end
	else if (cnt_reg >= limit)
	begin
		cnt_reg <= 6'h00;
		tick_reg <= 1'b1;
	end
	else
	begin
		cnt_reg <= cnt_reg + 6'h01;
		tick_reg <= 1'b0;
	end
end

endmodule // acs_clk_div

// *** hdl/acs_map.vh ***
// acs_map.vh: register offsets, field positions, reset values and timing counts
// assumes: included by the sequencer design files, APB byte addressing
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define ACS_OFF_CTRL0 12'h000
`define ACS_OFF_CTRL1 12'h004
`define ACS_OFF_PINEN 12'h008
`define ACS_OFF_RESH 12'h00c
`define ACS_OFF_RESL 12'h010
`define ACS_OFF_IRQC 12'h014

// ****************************************
// field positions
// ****************************************
`define ACS_C0_START 7
`define ACS_C0_BUSY 6
`define ACS_C0_POFF 5
`define ACS_C0_ISRC 4
`define ACS_C1_VBG 6
`define ACS_C1_FMT 5
`define ACS_C1_REF 4
`define ACS_IRQ_FLAG 6
`define ACS_IRQ_EN 3
`define ACS_IRQ_GEN 0

// ****************************************
// reset values and timing
// ****************************************
`define ACS_CTRL0_RST 8'h60
`define ACS_CTRL1_RST 8'h00
`define ACS_PINEN_RST 8'h00
`define ACS_DIV_UNDEF 3'h7
`define ACS_CONV_CLKS 5'h10

`endif

// *** hdl/acs_seq.v ***
// acs_seq.v: a/d conversion sequencer with apb register slave
// assumes: apb master on pclk, analog core gives a 12-bit sample, port logic takes overrides
//
// How it works
// - pin enable bit one selects analog input
// - upper pin enable bits read zero
// - start low-high-low begins one conversion
// - start held high resets, busy forced
// - busy clears by hardware at end
// - end sets irq flag; irq if enabled
// - converter clock is pclk over 1..64
// - analog pin drops its pull-high
// - analog pin overrides port direction
// - reference from vref pin or supply
// - conversion takes sixteen converter clocks, autonomous
// - channel code or internal bandgap selection
// - power-off bit resets to one
// - result left or right justified
`timescale 1ns/10ps
`include "acs_map.vh"
module acs_seq
#(
	parameter CONV_CLKS = `ACS_CONV_CLKS
)
(
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// analog core
	input wire [11:0] conv_sample,
	output reg conv_reset_reg,
	output reg conv_sample_reg,
	output reg conv_power_off,
	output reg [3:0] analog_mux_sel,
	output reg internal_source_sel,
	output reg bandgap_en,
	output reg ref_source_sel,
	// port overrides
	output reg [3:0] pin_analog_en,
	output reg [3:0] pin_pullup_dis,
	output reg [3:0] pin_dir_override,
	// interrupt
	output reg conv_irq
);

// ****************************************
// state
// ****************************************
localparam ST_IDLE = 2'b00;
localparam ST_RESET = 2'b01;
localparam ST_CONV = 2'b10;

// ****************************************
// reset images
// ****************************************
localparam [7:0] CTRL0_RST = `ACS_CTRL0_RST;
localparam [7:0] CTRL1_RST = `ACS_CTRL1_RST;
localparam [7:0] PINEN_RST = `ACS_PINEN_RST;

reg [1:0] state_reg;
reg [1:0] state_next;
reg start_reg;
reg conv_busy_flag;
reg [1:0] channel_sel;
reg [2:0] conv_clk_div_sel;
reg result_format_sel;
reg [3:0] pin_analog_en_field;
reg conv_irq_flag;
reg conv_irq_enable;
reg global_irq_enable;
reg [11:0] result_reg;
reg [4:0] tick_cnt_reg;
wire conv_tick;
wire wr_en;
wire rd_en;
wire addr_ok;
wire conv_done;
reg [7:0] rd_mux;

// writes land on the pready edge only; a held access re-pulses pready every other cycle and writes again on each pulse
assign wr_en = psel & penable & pwrite & pready;
assign rd_en = psel & penable & ~pwrite;
assign addr_ok = (paddr == `ACS_OFF_CTRL0) | (paddr == `ACS_OFF_CTRL1) |
	(paddr == `ACS_OFF_PINEN) | (paddr == `ACS_OFF_RESH) |
	(paddr == `ACS_OFF_RESL) | (paddr == `ACS_OFF_IRQC);
assign conv_done = (state_reg == ST_CONV) & conv_tick &
	(tick_cnt_reg == CONV_CLKS[4:0] - 5'h01);

// ****************************************
// converter clock
// ****************************************
acs_clk_div u_div
(
	.pclk(pclk),
	.presetn(presetn),
	.clr(state_reg != ST_CONV),
	.div_sel(conv_clk_div_sel),
	.tick_reg(conv_tick)
);

// ****************************************
// sequencer
// ****************************************
always @*
begin
	state_next = state_reg;
	case (state_reg)
		ST_IDLE:
		begin
			if (start_reg)
				state_next = ST_RESET;
		end
		ST_RESET:
		begin
			if (!start_reg)
				state_next = ST_CONV;
		end
		ST_CONV:
		begin
			if (start_reg)
				state_next = ST_RESET;
			else if (conv_done)
				state_next = ST_IDLE;
		end
		default:
			state_next = ST_IDLE;
	endcase
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		state_reg <= ST_IDLE;
		tick_cnt_reg <= 5'h00;
		conv_busy_flag <= CTRL0_RST[`ACS_C0_BUSY];
		result_reg <= 12'h000;
	end
	else
	begin
		state_reg <= state_next;
		if (state_reg != ST_CONV)
			tick_cnt_reg <= 5'h00;
		else if (conv_tick)
			tick_cnt_reg <= tick_cnt_reg + 5'h01;
		if (state_next == ST_RESET)
			conv_busy_flag <= 1'b1;
		else if (conv_done)
			conv_busy_flag <= 1'b0;
		if (conv_done)
			result_reg <= conv_sample;
	end
end

// ****************************************
// register writes
// ****************************************
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		start_reg <= CTRL0_RST[`ACS_C0_START];
		conv_power_off <= CTRL0_RST[`ACS_C0_POFF];
		internal_source_sel <= CTRL0_RST[`ACS_C0_ISRC];
		channel_sel <= CTRL0_RST[1:0];
		bandgap_en <= CTRL1_RST[`ACS_C1_VBG];
		result_format_sel <= CTRL1_RST[`ACS_C1_FMT];
		ref_source_sel <= CTRL1_RST[`ACS_C1_REF];
		conv_clk_div_sel <= CTRL1_RST[2:0];
		pin_analog_en_field <= PINEN_RST[3:0];
		conv_irq_flag <= 1'b0;
		conv_irq_enable <= 1'b0;
		global_irq_enable <= 1'b0;
	end
	else
	begin
		if (wr_en && paddr == `ACS_OFF_CTRL0)
		begin
			start_reg <= pwdata[`ACS_C0_START];
			conv_power_off <= pwdata[`ACS_C0_POFF];
			internal_source_sel <= pwdata[`ACS_C0_ISRC];
			channel_sel <= pwdata[1:0];
		end
		if (wr_en && paddr == `ACS_OFF_CTRL1)
		begin
			bandgap_en <= pwdata[`ACS_C1_VBG];
			result_format_sel <= pwdata[`ACS_C1_FMT];
			ref_source_sel <= pwdata[`ACS_C1_REF];
			conv_clk_div_sel <= pwdata[2:0];
		end
		if (wr_en && paddr == `ACS_OFF_PINEN)
			pin_analog_en_field <= pwdata[3:0];
		if (wr_en && paddr == `ACS_OFF_IRQC)
		begin
			conv_irq_enable <= pwdata[`ACS_IRQ_EN];
			global_irq_enable <= pwdata[`ACS_IRQ_GEN];
		end
		// set wins over a software clear in the same cycle
		if (conv_done)
			conv_irq_flag <= 1'b1;
		else if (wr_en && paddr == `ACS_OFF_IRQC)
			conv_irq_flag <= pwdata[`ACS_IRQ_FLAG];
	end
end

// ****************************************
// read mux and apb answer
// ****************************************
always @*
begin
	rd_mux = 8'h00;
	case (paddr)
		`ACS_OFF_CTRL0:
			rd_mux = {start_reg, conv_busy_flag, conv_power_off, internal_source_sel,
				2'b00, channel_sel};
		`ACS_OFF_CTRL1:
			rd_mux = {1'b0, bandgap_en, result_format_sel, ref_source_sel, 1'b0,
				conv_clk_div_sel};
		`ACS_OFF_PINEN:
			rd_mux = {4'h0, pin_analog_en_field};
		`ACS_OFF_RESH:
			rd_mux = result_format_sel ? {4'h0, result_reg[11:8]} :
				result_reg[11:4];
		`ACS_OFF_RESL:
			rd_mux = result_format_sel ? result_reg[7:0] :
				{result_reg[3:0], 4'h0};
		`ACS_OFF_IRQC:
			rd_mux = {1'b0, conv_irq_flag, 2'b00, conv_irq_enable, 2'b00,
				global_irq_enable};
		default:
			rd_mux = 8'h00;
	endcase
end

// one wait state: answer in the access phase's second cycle
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end
	else
	begin
		pready <= psel & penable & ~pready;
		pslverr <= psel & penable & ~pready & ~addr_ok;
		if (rd_en && !pready)
			prdata <= {24'h000000, rd_mux};
	end
end

// ****************************************
// outputs to analog core and ports
// ****************************************
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		conv_reset_reg <= 1'b1;
		conv_sample_reg <= 1'b0;
		analog_mux_sel <= 4'h0;
		pin_analog_en <= 4'h0;
		pin_pullup_dis <= 4'h0;
		pin_dir_override <= 4'h0;
		conv_irq <= 1'b0;
	end
	else
	begin
		conv_reset_reg <= (state_next == ST_RESET) | conv_power_off;
		// a powered-off converter stops sampling one pclk after conv_power_off is set
		conv_sample_reg <= (state_next == ST_CONV) & ~conv_power_off;
		// bandgap disconnects every external channel
		analog_mux_sel <= internal_source_sel ? 4'h0 : (4'h1 << channel_sel);
		pin_analog_en <= pin_analog_en_field;
		pin_pullup_dis <= pin_analog_en_field;
		pin_dir_override <= pin_analog_en_field;
		conv_irq <= (conv_irq_flag | conv_done) & conv_irq_enable & global_irq_enable;
	end
end

// ref_source_sel drives the reference switch directly: 1 vref pin, 0 supply

endmodule // acs_seq
